// ===== core/pie_bank.v
// second peripheral interrupt enable bank with wishbone registers
//
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
`include "pie_consts.vh"
module pie_bank (
    // clock and reset
    input  wire        ref_clk,
    input  wire        rst,
    // package variant strap
    input  wire        small_package,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // source requests, bit positions as the enable register
    input  wire [7:0]  src_req,
    // gated requests toward the interrupt logic
    output reg  [7:0]  irq_req,
    // interrupt for events in this block
    output reg         irq
);
    reg  [7:0] peripheral_irq_enable_second;
    reg  [1:0] control;
    reg  [7:0] status;
    reg  [7:0] mask;
    reg  [7:0] prev_req;
    reg        small_q;
    wire [7:0] gated;
    wire [7:0] impl = small_q ? `PIE_IMPL_SMALL : `PIE_IMPL_FULL;
    wire       access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       wr = access & wb_we_i & wb_sel_i[0];
    wire       rd_status = access & ~wb_we_i &
                           (wb_adr_i == `PIE_ADDR_STATUS);
    wire [7:0] rise = gated & ~prev_req;
    reg  [7:0] next_status;

    // strap caught in a clocked process
    always @(posedge ref_clk) begin
        if (rst)
            small_q <= small_package;
    end

    pie_gate u_gate (
        .ref_clk                 (ref_clk),
        .rst                     (rst),
        .enable                  (peripheral_irq_enable_second),
        .priority_levels_en      (control[`PIE_CTRL_PRIO]),
        .peripheral_group_irq_en (control[`PIE_CTRL_GROUP]),
        .req_in                  (src_req),
        .req_out                 (gated)
    );

    // set wins over read clear
    always @* begin
        next_status = rd_status ? 8'h00 : status;
        next_status = next_status | rise;
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            peripheral_irq_enable_second <= `PIE_ENABLE_RESET;
            control  <= `PIE_CTRL_RESET;
            status   <= 8'h00;
            mask     <= 8'h00;
            prev_req <= 8'h00;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            irq_req  <= 8'h00;
            irq      <= 1'b0;
        end else begin
            prev_req <= gated;
            irq_req  <= gated;
            status   <= next_status;
            irq      <= |(next_status & mask);
            wb_ack_o <= access;
            if (wr) begin
                case (wb_adr_i)
                    `PIE_ADDR_ENABLE:
                        peripheral_irq_enable_second <=
                            wb_dat_i[7:0] & impl;
                    `PIE_ADDR_MASK:    mask <= wb_dat_i[7:0] & impl;
                    `PIE_ADDR_CONTROL: control <= wb_dat_i[1:0];
                    default: ;
                endcase
            end
            if (access & ~wb_we_i) begin
                case (wb_adr_i)
                    `PIE_ADDR_ENABLE:
                        wb_dat_o <= {24'h000000,
                            peripheral_irq_enable_second & impl};
                    `PIE_ADDR_STATUS:  wb_dat_o <= {24'h000000, status};
                    `PIE_ADDR_MASK:    wb_dat_o <= {24'h000000, mask};
                    `PIE_ADDR_CONTROL: wb_dat_o <= {30'h0, control};
                    default:           wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // pie_bank

// ===== core/pie_consts.vh
// constants for the second peripheral interrupt enable bank
`ifndef PIE_CONSTS_VH
`define PIE_CONSTS_VH
`define PIE_ADDR_ENABLE   4'h0
`define PIE_ADDR_STATUS   4'h4
`define PIE_ADDR_MASK     4'h8
`define PIE_ADDR_CONTROL  4'hC
`define PIE_BIT_ENH_CAP   0
`define PIE_BIT_TIMER3    1
`define PIE_BIT_LOW_VOLT  2
`define PIE_BIT_BUS_COLL  3
`define PIE_BIT_EEPROM    4
`define PIE_BIT_COMP      6
`define PIE_IMPL_FULL     8'h5F
`define PIE_IMPL_SMALL    8'h1E
`define PIE_ENABLE_RESET  8'h00
`define PIE_CTRL_PRIO     0
`define PIE_CTRL_GROUP    1
`define PIE_CTRL_RESET    2'h0
`endif

// ===== core/pie_gate.v
// gating of eight source requests by enable and group bits
`timescale 1ns/100ps
module pie_gate (
    // clock and reset
    input  wire       ref_clk,
    input  wire       rst,
    // controls
    input  wire [7:0] enable,
    input  wire       priority_levels_en,
    input  wire       peripheral_group_irq_en,
    // sources and result
    input  wire [7:0] req_in,
    output reg  [7:0] req_out
);
    wire group_ok = priority_levels_en | peripheral_group_irq_en;
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_bit
            always @(posedge ref_clk) begin
                if (rst)
                    req_out[i] <= 1'b0;
                else
                    req_out[i] <= req_in[i] & enable[i] & group_ok;
            end
        end
    endgenerate
endmodule // pie_gate

// ===== test/pie_checker.sv
// assertions on the ports of the second enable bank
`timescale 1ns/100ps
module pie_checker (
    // clock, reset and strap
    input wire       ref_clk, rst, small_package,
    // bus handshake
    input wire       wb_cyc_i, wb_stb_i, wb_ack_o,
    // requests
    input wire [7:0] src_req, irq_req
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_comp_gated: assert property (irq_req[6] |-> $past(src_req[6], 2))
        else $error("comparator request passed without its source");
    a_coll_gated: assert property (irq_req[3] |-> $past(src_req[3], 2))
        else $error("collision request passed without its source");
    a_tmr3_gated: assert property (irq_req[1] |-> $past(src_req[1], 2))
        else $error("timer3 request passed without its source");
    a_small_unimpl: assert property (small_package |-> !irq_req[6] &&
        !irq_req[0]) else $error("unimplemented request passed");
    a_reset_clear: assert property ($fell(rst) |-> (irq_req == 8'h00)[*3])
        else $error("request passed right after reset");
    a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o ##1 !wb_ack_o) else $error("bus answer not one pulse");
    a_other_gated: assert property ((irq_req & 8'h15 &
        ~$past(src_req, 2)) == 8'h00) else $error("request without source");
    a_unimpl_zero: assert property (!irq_req[7] && !irq_req[5])
        else $error("request on unimplemented bit");
endmodule // pie_checker
bind pie_bank pie_checker u_pie_checker (.ref_clk(ref_clk), .rst(rst),
    .small_package(small_package), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .src_req(src_req), .irq_req(irq_req));

// ===== test/tb_top.sv
// testbench for the second enable bank
`timescale 1ns/100ps
module tb_top;
    logic ref_clk = 0, rst = 1, small_package = 0, wb_ack_o, irq;
    logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [3:0] wb_adr_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
    logic [7:0] src_req = 0, irq_req;
    int fails = 0, n_compared = 0;
    pie_bank u_pie_bank (.ref_clk(ref_clk), .rst(rst), .irq(irq),
        .small_package(small_package), .wb_cyc_i(wb_cyc_i), .wb_sel_i(4'hF),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .src_req(src_req), .irq_req(irq_req));
    initial forever #50 ref_clk = ~ref_clk;
    task final_report;
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] s, e);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge ref_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        do begin
            @(posedge ref_clk);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 20);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        if (i >= 20) begin
            fails++;
            final_report;
        end
    endtask
    task settle; repeat (4) @(posedge ref_clk); endtask
    task do_reset(input logic sp);
        small_package <= sp;
        rst <= 1;
        repeat (16) @(posedge ref_clk);
        rst <= 0;
    endtask
    task t_gate;
        wb(0, 4'h0, 0); chk("enable reset", rd, 32'h0);
        src_req <= 8'hFF; wb(1, 4'h0, 32'hFF);
        wb(0, 4'h0, 0); chk("enable rw", rd, 32'h5F);
        settle; chk("no group", irq_req, 8'h00);
        wb(1, 4'hC, 2); settle; chk("group", irq_req, 8'h5F);
        wb(1, 4'hC, 1); settle; chk("prio", irq_req, 8'h5F);
        wb(1, 4'h0, 8); settle; chk("coll", irq_req, 8'h08);
        wb(0, 4'h2, 0); chk("unmapped", rd, 32'h0);
    endtask
    task t_irq;
        wb(0, 4'h4, 0); wb(1, 4'h0, 2);
        settle; chk("tmr3", irq_req, 8'h02); chk("masked", irq, 0);
        wb(1, 4'h8, 2); settle; chk("irq on", irq, 1);
        wb(0, 4'h4, 0); chk("status", rd, 32'h2);
        settle; chk("irq off", irq, 0);
    endtask
    task t_small;
        do_reset(1); wb(1, 4'h0, 32'hFF);
        wb(0, 4'h0, 0); chk("small rw", rd, 32'h1E);
        wb(1, 4'hC, 2); settle; chk("small", irq_req, 8'h1E);
    endtask
    initial begin
        do_reset(0); t_gate; t_irq; t_small; final_report;
    end
endmodule // tb_top
